// >>> hdl/usbls_cfg.svh
/*
  usbls_cfg.svh: offsets, field positions, reset values and timing counts of the
  usb device link, state and power block.
  assumes a 200 MHz system clock and byte offsets on the plain register port.
*/
`ifndef USBLS_CFG_SVH
`define USBLS_CFG_SVH

// ----------------------------------------------------------------------------
// clocking
// ----------------------------------------------------------------------------
`define USBLS_CLK_MHZ        8'd200
`define USBLS_ENG_MHZ        8'd48
`define USBLS_FS_BIT_CLKS    6'd4
`define USBLS_LS_BIT_CLKS    6'd32
`define USBLS_CYC_PER_US     200

// ----------------------------------------------------------------------------
// line timing in microseconds
// ----------------------------------------------------------------------------
`define USBLS_SUSPEND_US     3000
`define USBLS_RESET_US       2500
`define USBLS_RESUME_US      2000
`define USBLS_CHIRP_US       1000
`define USBLS_HUBWAIT_US     2000
`define USBLS_US2CYC(us)     ((us) * `USBLS_CYC_PER_US)
`define USBLS_TMR_W          20
`define USBLS_EOP_SE0_BITS   2'd2
`define USBLS_HUB_PAIRS      2'd3

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define USBLS_ADDR_W         4
`define USBLS_DATA_W         16
`define USBLS_OFS_CTRL       4'h0
`define USBLS_OFS_POWER      4'h4
`define USBLS_OFS_STATUS     4'h8
`define USBLS_OFS_CFG        4'hc

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define USBLS_CTRL_LS        0
`define USBLS_CTRL_HSCAP     1
`define USBLS_CTRL_SELFPWR   2
`define USBLS_CTRL_RWU_EN    3
`define USBLS_CTRL_RWU_REQ   4
`define USBLS_CTRL_RST       4'h0
`define USBLS_REQ_MA_RST     9'h064

`endif

// >>> hdl/usbls_pkg.sv
/*
  usbls_pkg: types of the usb device link, state and power block.
  assumes nothing beyond a systemverilog compiler.
*/
package usbls_pkg;

  // --------------------------------------------------------------------------
  // device states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_ATTACHED,
    DEV_POWERED,
    DEV_DEFAULT,
    DEV_ADDRESS,
    DEV_CONFIGURED
  } usbls_dev_e;

  // --------------------------------------------------------------------------
  // link signalling states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_FS,
    LK_CHIRP,
    LK_HUBWAIT,
    LK_HS,
    LK_RESUME
  } usbls_link_e;

endpackage

// >>> hdl/usbls_sync.sv
/*
  usbls_sync: two flip-flop synchroniser for pin levels.
  assumes inputs are slow levels from outside the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module usbls_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // usbls_sync

`default_nettype wire

// >>> hdl/usbls_timer.sv
/*
  usbls_timer: saturating cycle counter with a limit compare.
  assumes clear and limit come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "usbls_cfg.svh"

module usbls_timer (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // control
  input  wire logic                   clear,
  input  wire logic [`USBLS_TMR_W-1:0] limit,
  // status
  output logic                        done
);

  logic [`USBLS_TMR_W-1:0] cnt_reg;

  assign done = (cnt_reg >= limit);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (clear) begin
      cnt_reg <= '0;
    end else if (!done) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule // usbls_timer

`default_nettype wire

// >>> hdl/usbls_top.sv
/*
  usbls_top: usb device link housekeeping: bit timing, speed pull-ups and chirp,
  suspend and resume, vbus watch, device states and power request encoding.
  assumes a 200 MHz clock, an external transceiver on the pins, and a serial
  engine on the same clock that reports address and configuration commands.

*/
`timescale 1ns/10ps
`default_nettype none
`include "usbls_cfg.svh"

module usbls_top #(
  parameter int unsigned SUSPEND_CYCLES = `USBLS_US2CYC(`USBLS_SUSPEND_US),
  parameter int unsigned RESET_CYCLES   = `USBLS_US2CYC(`USBLS_RESET_US),
  parameter int unsigned RESUME_CYCLES  = `USBLS_US2CYC(`USBLS_RESUME_US),
  parameter int unsigned CHIRP_CYCLES   = `USBLS_US2CYC(`USBLS_CHIRP_US),
  parameter int unsigned HUBWAIT_CYCLES = `USBLS_US2CYC(`USBLS_HUBWAIT_US)
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // register port
  input  wire logic [`USBLS_ADDR_W-1:0] reg_addr,
  input  wire logic [`USBLS_DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output var  logic [`USBLS_DATA_W-1:0] reg_rdata,
  // bus pins
  input  wire logic                     dp_in,
  input  wire logic                     dm_in,
  output var  logic                     dp_out,
  output var  logic                     dm_out,
  output var  logic                     dx_oe,
  output var  logic                     pu_dp_en,
  output var  logic                     pu_dm_en,
  input  wire logic                     vbus_sense,
  // serial engine side
  input  wire logic                     hs_rx_active,
  input  wire logic                     set_addr_stb,
  input  wire logic [6:0]               set_addr_val,
  input  wire logic                     set_cfg_stb,
  input  wire logic [7:0]               set_cfg_val,
  input  wire logic [6:0]               tok_addr,
  output logic                          addr_match,
  // timing and events
  output var  logic                     engine_tick,
  output var  logic                     bit_tick,
  output var  logic                     eop_seen,
  output var  logic                     bus_reset,
  // state and power
  output var  usbls_pkg::usbls_dev_e    dev_state,
  output var  logic [6:0]               dev_addr,
  output var  logic [7:0]               cfg_value,
  output var  logic                     suspended,
  output logic                          high_speed,
  output logic                          full_power_ok,
  output var  logic [8:0]               power_units
);

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function automatic logic line_is_j(input logic ls, input logic dp, input logic dm);
    line_is_j = ls ? (!dp && dm) : (dp && !dm);
  endfunction

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic                     dp_s, dm_s, vbus_s;
  logic [1:0]               line_prev_reg;
  logic [3:0]               ctrl_reg;
  logic [8:0]               req_ma_reg;
  logic                     rwu_pulse;
  logic [7:0]               acc_reg;
  logic [8:0]               acc_sum;
  logic                     eng_hit;
  logic [5:0]               bit_cnt_reg;
  logic [5:0]               bit_period;
  logic                     bit_hit;
  logic [1:0]               se0_bits_reg;
  logic                     ls, hs_cap, self_pwr, rwu_en;
  logic                     j_st, k_st, se0;
  logic                     drv, line_chg, activity;
  logic [2:0]               drv_tail_reg;
  logic                     vbus_ok, pu_on;
  logic                     idle_done, se0_done, se0_done_d, phase_done;
  logic                     suspend_hit, reset_hit;
  logic [`USBLS_TMR_W-1:0]  phase_limit;
  usbls_pkg::usbls_link_e   link_reg, link_next;
  usbls_pkg::usbls_dev_e    dev_next;
  logic                     phase_clr;
  logic                     seen_k_reg;
  logic [1:0]               pairs_reg;
  logic                     wr_ctrl, wr_power;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  usbls_sync #(.W(3)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({dp_in, dm_in, vbus_sense}),
    .q       ({dp_s, dm_s, vbus_s})
  );

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------
  assign wr_ctrl   = reg_wr && (reg_addr == `USBLS_OFS_CTRL);
  assign wr_power  = reg_wr && (reg_addr == `USBLS_OFS_POWER);
  assign rwu_pulse = wr_ctrl && reg_wdata[`USBLS_CTRL_RWU_REQ];
  assign ls        = ctrl_reg[`USBLS_CTRL_LS];
  assign hs_cap    = ctrl_reg[`USBLS_CTRL_HSCAP];
  assign self_pwr  = ctrl_reg[`USBLS_CTRL_SELFPWR];
  assign rwu_en    = ctrl_reg[`USBLS_CTRL_RWU_EN];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg   <= `USBLS_CTRL_RST;
      req_ma_reg <= `USBLS_REQ_MA_RST;
      reg_rdata  <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[3:0];
      end
      if (wr_power) begin
        req_ma_reg <= reg_wdata[8:0];
      end
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          `USBLS_OFS_CTRL:   reg_rdata <= {12'h000, ctrl_reg};
          `USBLS_OFS_POWER:  reg_rdata <= {7'h00, req_ma_reg};
          `USBLS_OFS_STATUS: reg_rdata <= {1'b0, dev_addr, 1'b0, dx_oe, vbus_s, high_speed, suspended, dev_state};
          `USBLS_OFS_CFG:    reg_rdata <= {8'h00, cfg_value};
          default:           reg_rdata <= '0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // engine tick and bit timing
  // --------------------------------------------------------------------------
  assign acc_sum    = {1'b0, acc_reg} + {1'b0, `USBLS_ENG_MHZ};
  assign eng_hit    = (acc_sum >= {1'b0, `USBLS_CLK_MHZ});
  assign bit_period = ls ? `USBLS_LS_BIT_CLKS : `USBLS_FS_BIT_CLKS;
  assign bit_hit    = eng_hit && (bit_cnt_reg == bit_period - 6'd1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg     <= '0;
      bit_cnt_reg <= '0;
      engine_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else begin
      acc_reg     <= eng_hit ? 8'(acc_sum - {1'b0, `USBLS_CLK_MHZ}) : acc_sum[7:0];
      engine_tick <= eng_hit;
      bit_tick    <= bit_hit;
      if (bit_hit) begin
        bit_cnt_reg <= '0;
      end else if (eng_hit) begin
        bit_cnt_reg <= bit_cnt_reg + 6'd1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // line state decode and activity
  // --------------------------------------------------------------------------
  assign j_st     = line_is_j(ls, dp_s, dm_s);
  assign k_st     = line_is_j(!ls, dp_s, dm_s);
  assign se0      = !dp_s && !dm_s;
  assign drv      = dx_oe || (|drv_tail_reg);
  assign line_chg = ({dp_s, dm_s} != line_prev_reg);
  assign activity = high_speed ? hs_rx_active : (!drv && (!j_st || line_chg));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_prev_reg <= '0;
      drv_tail_reg  <= '0;
      se0_done_d    <= 1'b0;
      bus_reset     <= 1'b0;
    end else begin
      line_prev_reg <= {dp_s, dm_s};
      drv_tail_reg  <= {drv_tail_reg[1:0], dx_oe};
      se0_done_d    <= se0_done;
      bus_reset     <= reset_hit;
    end
  end

  // --------------------------------------------------------------------------
  // end-of-packet detect
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      se0_bits_reg <= '0;
      eop_seen     <= 1'b0;
    end else begin
      eop_seen <= 1'b0;
      if (drv || high_speed) begin
        se0_bits_reg <= '0;
      end else if (se0) begin
        if (bit_hit && se0_bits_reg != 2'd3) begin
          se0_bits_reg <= se0_bits_reg + 2'd1;
        end
      end else if (j_st && se0_bits_reg >= `USBLS_EOP_SE0_BITS) begin
        if (bit_hit) begin
          eop_seen     <= 1'b1;
          se0_bits_reg <= '0;
        end
      end else begin
        se0_bits_reg <= '0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // timers
  // --------------------------------------------------------------------------
  usbls_timer u_idle (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (activity || dev_state == usbls_pkg::DEV_ATTACHED),
    .limit   (`USBLS_TMR_W'(SUSPEND_CYCLES)),
    .done    (idle_done)
  );

  usbls_timer u_se0 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (!se0 || drv || high_speed),
    .limit   (`USBLS_TMR_W'(RESET_CYCLES)),
    .done    (se0_done)
  );

  usbls_timer u_phase (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (phase_clr),
    .limit   (phase_limit),
    .done    (phase_done)
  );

  assign suspend_hit = idle_done && !suspended;
  assign reset_hit   = se0_done && !se0_done_d && vbus_s;
  assign phase_clr   = (link_next != link_reg);
  assign phase_limit = (link_reg == usbls_pkg::LK_CHIRP)  ? `USBLS_TMR_W'(CHIRP_CYCLES) :
                       (link_reg == usbls_pkg::LK_RESUME) ? `USBLS_TMR_W'(RESUME_CYCLES) :
                                                            `USBLS_TMR_W'(HUBWAIT_CYCLES);

  // --------------------------------------------------------------------------
  // link signalling machine
  // --------------------------------------------------------------------------
  always_comb begin
    link_next = link_reg;
    unique case (link_reg)
      usbls_pkg::LK_FS: begin
        if (reset_hit && hs_cap && !ls) begin
          link_next = usbls_pkg::LK_CHIRP;
        end else if (suspended && rwu_en && rwu_pulse) begin
          link_next = usbls_pkg::LK_RESUME;
        end
      end
      usbls_pkg::LK_CHIRP: begin
        if (phase_done) begin
          link_next = usbls_pkg::LK_HUBWAIT;
        end
      end
      usbls_pkg::LK_HUBWAIT: begin
        if (pairs_reg == `USBLS_HUB_PAIRS) begin
          link_next = usbls_pkg::LK_HS;
        end else if (phase_done) begin
          link_next = usbls_pkg::LK_FS;
        end
      end
      usbls_pkg::LK_HS: begin
        if (suspend_hit) begin
          link_next = usbls_pkg::LK_FS;
        end
      end
      usbls_pkg::LK_RESUME: begin
        if (phase_done) begin
          link_next = usbls_pkg::LK_FS;
        end
      end
    endcase
    if (!vbus_ok) begin
      link_next = usbls_pkg::LK_FS;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_reg   <= usbls_pkg::LK_FS;
      seen_k_reg <= 1'b0;
      pairs_reg  <= '0;
    end else begin
      link_reg <= link_next;
      if (link_reg != usbls_pkg::LK_HUBWAIT) begin
        seen_k_reg <= 1'b0;
        pairs_reg  <= '0;
      end else if (k_st && !drv) begin
        seen_k_reg <= 1'b1;
      end else if (j_st && seen_k_reg) begin
        seen_k_reg <= 1'b0;
        pairs_reg  <= pairs_reg + 2'd1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // pin drive and pull-ups
  // --------------------------------------------------------------------------
  assign high_speed = (link_reg == usbls_pkg::LK_HS);
  assign vbus_ok    = vbus_s || !self_pwr;
  assign pu_on      = vbus_ok && vbus_s && (link_next != usbls_pkg::LK_HS);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dx_oe    <= 1'b0;
      dp_out   <= 1'b0;
      dm_out   <= 1'b0;
      pu_dp_en <= 1'b0;
      pu_dm_en <= 1'b0;
    end else begin
      dx_oe    <= (link_next == usbls_pkg::LK_CHIRP) || (link_next == usbls_pkg::LK_RESUME);
      dp_out   <= ls;
      dm_out   <= !ls;
      pu_dp_en <= pu_on && !ls;
      pu_dm_en <= pu_on && ls;
    end
  end

  // --------------------------------------------------------------------------
  // device state machine
  // --------------------------------------------------------------------------
  always_comb begin
    dev_next = dev_state;
    unique case (dev_state)
      usbls_pkg::DEV_ATTACHED: begin
        if (vbus_s) begin
          dev_next = usbls_pkg::DEV_POWERED;
        end
      end
      usbls_pkg::DEV_POWERED: begin
      end
      usbls_pkg::DEV_DEFAULT: begin
        if (set_addr_stb && set_addr_val != 7'h00) begin
          dev_next = usbls_pkg::DEV_ADDRESS;
        end
      end
      usbls_pkg::DEV_ADDRESS: begin
        if (set_addr_stb && set_addr_val == 7'h00) begin
          dev_next = usbls_pkg::DEV_DEFAULT;
        end else if (set_cfg_stb && set_cfg_val != 8'h00) begin
          dev_next = usbls_pkg::DEV_CONFIGURED;
        end
      end
      usbls_pkg::DEV_CONFIGURED: begin
        if (set_cfg_stb && set_cfg_val == 8'h00) begin
          dev_next = usbls_pkg::DEV_ADDRESS;
        end
      end
    endcase
    if (reset_hit && dev_state != usbls_pkg::DEV_ATTACHED) begin
      dev_next = usbls_pkg::DEV_DEFAULT;
    end
    if (!vbus_s) begin
      dev_next = usbls_pkg::DEV_ATTACHED;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dev_state <= usbls_pkg::DEV_ATTACHED;
      dev_addr  <= '0;
      cfg_value <= '0;
    end else begin
      dev_state <= dev_next;
      if (dev_next == usbls_pkg::DEV_ATTACHED || dev_next == usbls_pkg::DEV_POWERED ||
          dev_next == usbls_pkg::DEV_DEFAULT) begin
        dev_addr  <= '0;
        cfg_value <= '0;
      end else begin
        if (set_addr_stb && dev_state == usbls_pkg::DEV_DEFAULT) begin
          dev_addr <= set_addr_val;
        end
        if (set_cfg_stb && dev_state != usbls_pkg::DEV_DEFAULT) begin
          cfg_value <= set_cfg_val;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // suspend, address match and power
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      suspended   <= 1'b0;
      power_units <= '0;
    end else begin
      power_units <= 9'((10'(req_ma_reg) + 10'd1) >> 1);
      if (!vbus_s) begin
        suspended <= 1'b0;
      end else if (suspend_hit && dev_state != usbls_pkg::DEV_ATTACHED) begin
        suspended <= 1'b1;
      end else if (activity) begin
        suspended <= 1'b0;
      end
    end
  end

  assign addr_match    = (dev_state == usbls_pkg::DEV_DEFAULT) ? (tok_addr == 7'h00) :
                         (dev_state == usbls_pkg::DEV_ADDRESS ||
                          dev_state == usbls_pkg::DEV_CONFIGURED) ? (tok_addr == dev_addr) : 1'b0;
  assign full_power_ok = (dev_state == usbls_pkg::DEV_CONFIGURED) && !suspended;

endmodule // usbls_top

`default_nettype wire

// >>> verification/usbls_chk.sv
/* usbls_chk: assertions and covers on the ports of usbls_top.
   assumes one clock, reset active high, bound below. */
`timescale 1ns/10ps
`default_nettype none
module usbls_chk (
  // watched ports
  input wire logic                  clk, sys_rst, vbus_sense, addr_match, set_addr_stb, bus_reset,
  input wire logic                  pu_dp_en, pu_dm_en, high_speed, full_power_ok, suspended,
  input wire logic                  engine_tick, dx_oe, dp_out, dm_out,
  input wire logic [6:0]            tok_addr, dev_addr, set_addr_val,
  input wire usbls_pkg::usbls_dev_e dev_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  pu_one_a: assert property (!(pu_dp_en && pu_dm_en)) else $error("both pull-ups on");
  hs_pu_a: assert property (high_speed |-> !pu_dp_en && !pu_dm_en) else $error("pull-up in hs");
  vbus_off_a: assert property (!vbus_sense [*4] |=> !pu_dp_en && !pu_dm_en
    && dev_state == usbls_pkg::DEV_ATTACHED) else $error("vbus loss kept state");
  dflt_addr_a: assert property (dev_state == usbls_pkg::DEV_DEFAULT |-> addr_match == (tok_addr == 7'h00))
    else $error("default match wrong");
  own_addr_a: assert property (dev_state == usbls_pkg::DEV_ADDRESS |->
    addr_match == (tok_addr == dev_addr)) else $error("address match wrong");
  set_addr_a: assert property (set_addr_stb && set_addr_val != 7'h00 &&
    dev_state == usbls_pkg::DEV_DEFAULT |=> bus_reset ||
    (dev_state == usbls_pkg::DEV_ADDRESS && dev_addr == $past(set_addr_val))) else $error("set addr");
  full_pwr_a: assert property (full_power_ok |-> dev_state == usbls_pkg::DEV_CONFIGURED && !suspended)
    else $error("full power early");
  rst_dflt_a: assert property ($rose(bus_reset) |-> ##[0:1] dev_state == usbls_pkg::DEV_DEFAULT
    && dev_addr == 7'h00) else $error("reset kept state");
  tick_gap_a: assert property (engine_tick |=> !engine_tick) else $error("engine tick too fast");
  k_drive_a: assert property (dx_oe && (pu_dp_en || pu_dm_en) |->
    dp_out == pu_dm_en && dm_out == pu_dp_en) else $error("drive not k");
  cover property (suspended);
  cover property (high_speed);
  cover property (dx_oe);
  cover property (dev_state == usbls_pkg::DEV_CONFIGURED);
endmodule // usbls_chk
bind usbls_top usbls_chk i_usbls_chk (.*);
`default_nettype wire

// >>> verification/usbls_host.sv
/* usbls_host: host port driving the data lines, idle J unless told otherwise.
   assumes the bench steers se0 and k requests. */
`timescale 1ns/10ps
`default_nettype none
module usbls_host (
  // line requests
  input  wire logic ls, se0, kst,
  // device side
  input  wire logic pu_dp_en, pu_dm_en,
  output logic      dp, dm, dev_seen
);
  assign dp = !se0 && !(kst ^ ls);
  assign dm = !se0 && (kst ^ ls);
  assign dev_seen = pu_dp_en || pu_dm_en;
endmodule // usbls_host
`default_nettype wire

// >>> verification/usbls_top_bench.sv
/* usbls_top_bench: directed scenarios for usbls_top.
   assumes short timing parameters and the host model. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", nm, e, s); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge clk); #1; n++; end \
  if (!(c)) begin err_count++; give_verdict; end end
module usbls_top_bench;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, vbus_sense = 0, ls = 0, se0 = 0, kst = 0;
  logic hs_rx_active = 0, set_addr_stb = 0, set_cfg_stb = 0, h_dp, h_dm;
  logic [3:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, rd_val;
  logic [6:0] set_addr_val = '0, tok_addr = '0, dev_addr;
  logic [7:0] set_cfg_val = '0, cfg_value;
  logic [8:0] power_units;
  logic dp_out, dm_out, dx_oe, pu_dp_en, pu_dm_en, addr_match, engine_tick, bit_tick, eop_seen;
  logic bus_reset, suspended, high_speed, full_power_ok, dev_seen;
  usbls_pkg::usbls_dev_e dev_state;
  wire dp_in = dx_oe ? dp_out : h_dp;
  wire dm_in = dx_oe ? dm_out : h_dm;
  int err_count = 0, samples_checked = 0, n;
  always #2.5 clk = ~clk;
  usbls_top #(.SUSPEND_CYCLES(400), .RESET_CYCLES(300), .RESUME_CYCLES(50), .CHIRP_CYCLES(40),
    .HUBWAIT_CYCLES(200)) i_usbls_top (.*);
  usbls_host i_usbls_host (.ls, .se0, .kst, .pu_dp_en, .pu_dm_en, .dp(h_dp), .dm(h_dm), .dev_seen(dev_seen));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) begin reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk) begin reg_rd <= 1'h1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'h0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic t_bits(input int exp);
    int e = 0;
    `WAIT(bit_tick)
    n = 0;
    do begin @(posedge clk); #1; e += engine_tick; n++; end while (!bit_tick && n < 300);
    `CHK("ticks per bit", exp, e)
  endtask
  task automatic t_power;
    rd(4'h4); `CHK("power reg", 16'h0064, rd_val)
    `CHK("units", 9'h032, power_units)
    wr(4'h4, 16'h0065); idle(2); `CHK("units odd", 9'h033, power_units)
    rd(4'h2); `CHK("unmapped", 16'h0000, rd_val)
    wr(4'h4, 16'h0064); wr(4'h0, 16'h0004);
    t_bits(4);
  endtask
  task automatic t_attach;
    idle(5); `CHK("state", usbls_pkg::DEV_ATTACHED, dev_state)
    `CHK("pu off", 1'h0, pu_dp_en)
    @(posedge clk) vbus_sense <= 1'h1;
    idle(5); `CHK("state", usbls_pkg::DEV_POWERED, dev_state)
    `CHK("pu dp", 1'h1, pu_dp_en)
  endtask
  task automatic t_enum;
    @(posedge clk) se0 <= 1'h1;
    `WAIT(bus_reset)
    @(posedge clk) se0 <= 1'h0;
    #1 `CHK("state", usbls_pkg::DEV_DEFAULT, dev_state)
    `CHK("match 0", 1'h1, addr_match)
    @(posedge clk) tok_addr <= 7'h05;
    #1 `CHK("match 5", 1'h0, addr_match)
    @(posedge clk) begin set_addr_stb <= 1'h1; set_addr_val <= 7'h05; end
    @(posedge clk) set_addr_stb <= 1'h0;
    #1 `CHK("state", usbls_pkg::DEV_ADDRESS, dev_state)
    `CHK("addr match", 1'h1, addr_match)
    @(posedge clk) begin set_cfg_stb <= 1'h1; set_cfg_val <= 8'h01; end
    @(posedge clk) set_cfg_stb <= 1'h0;
    #1 `CHK("state", usbls_pkg::DEV_CONFIGURED, dev_state)
    `CHK("full power", 1'h1, full_power_ok)
    rd(4'h8); `CHK("status", 16'h0524, rd_val)
    rd(4'hc); `CHK("cfg", 16'h0001, rd_val)
  endtask
  task automatic t_suspend;
    idle(300);
    @(posedge clk) se0 <= 1'h1;
    idle(50);
    @(posedge clk) se0 <= 1'h0;
    `WAIT(eop_seen)
    idle(300); `CHK("early suspend", 1'h0, suspended)
    `WAIT(suspended)
    `CHK("suspend power", 1'h0, full_power_ok)
  endtask
  task automatic t_resume;
    wr(4'h0, 16'h000c); wr(4'h0, 16'h001c); idle(2);
    `CHK("resume drive", 1'h1, dx_oe)
    `CHK("k dp", 1'h0, dp_out)
    `CHK("k dm", 1'h1, dm_out)
    `WAIT(!dx_oe) idle(6);
    `CHK("await host", 1'h1, suspended)
    @(posedge clk) kst <= 1'h1;
    idle(4);
    @(posedge clk) kst <= 1'h0;
    #1 `CHK("wake", 1'h0, suspended)
  endtask
  task automatic t_vbus;
    @(posedge clk) vbus_sense <= 1'h0;
    idle(5); `CHK("pu drop", 1'h0, pu_dp_en)
    `CHK("host sees none", 1'h0, dev_seen)
    `CHK("state", usbls_pkg::DEV_ATTACHED, dev_state)
    wr(4'h0, 16'h0005);
    @(posedge clk) begin ls <= 1'h1; vbus_sense <= 1'h1; end
    idle(5); `CHK("pu dm", 1'h1, pu_dm_en)
    `CHK("pu dp", 1'h0, pu_dp_en)
    `CHK("host sees dev", 1'h1, dev_seen)
    t_bits(32);
  endtask
  task automatic t_chirp;
    wr(4'h0, 16'h0006);
    @(posedge clk) begin ls <= 1'h0; se0 <= 1'h1; end
    `WAIT(bus_reset)
    `CHK("chirp k", 1'h1, dx_oe)
    `CHK("chirp pu", 1'h1, pu_dp_en)
    @(posedge clk) se0 <= 1'h0;
    `WAIT(!dx_oe) idle(4);
    repeat (3) begin
      @(posedge clk) kst <= 1'h1; idle(4);
      @(posedge clk) kst <= 1'h0; idle(4);
    end
    `CHK("hs", 1'h1, high_speed)
    `CHK("hs pu", 1'h0, pu_dp_en)
    `WAIT(suspended) `CHK("fs again", 1'h1, pu_dp_en)
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    t_power; t_attach; t_enum; t_suspend; t_resume; t_vbus; t_chirp;
    give_verdict;
  end
endmodule // usbls_top_bench
`default_nettype wire
